// >>> common/ppci_map.vh
// register map and constants of the pulse position command input
`ifndef PPCI_MAP_VH
`define PPCI_MAP_VH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define PPCI_OFS_CTRL 8'h00
`define PPCI_OFS_GEAR_A 8'h04
`define PPCI_OFS_GEAR_B 8'h08
`define PPCI_OFS_STATUS 8'h0c
`define PPCI_OFS_POS 8'h10
`define PPCI_OFS_IRQ_STAT 8'h14
`define PPCI_OFS_IRQ_MASK 8'h18

// ---------------------------------------------------------------
// ctrl fields
// ---------------------------------------------------------------
`define PPCI_CTRL_MODE_LO 0
`define PPCI_CTRL_MODE_HI 1
`define PPCI_CTRL_MODE_SRC 2
`define PPCI_CTRL_POS_LOGIC 3
`define PPCI_CTRL_ROT_DIR 4
`define PPCI_CTRL_W 5
`define PPCI_CTRL_RST 5'h10

// ---------------------------------------------------------------
// pulse input modes
// ---------------------------------------------------------------
`define PPCI_MODE_ONE 2'h0
`define PPCI_MODE_TWO 2'h1
`define PPCI_MODE_PHASE 2'h2

// ---------------------------------------------------------------
// status fields
// ---------------------------------------------------------------
`define PPCI_ST_WARN 5
`define PPCI_ST_ALARM 6
`define PPCI_ST_ABS 7

// ---------------------------------------------------------------
// irq bits
// ---------------------------------------------------------------
`define PPCI_IRQ_WARN 0
`define PPCI_IRQ_ALARM 1
`define PPCI_IRQ_W 2

// ---------------------------------------------------------------
// electronic gear
// ---------------------------------------------------------------
`define PPCI_GEAR_RST 16'h0001
`define PPCI_RES_BASE 40'h00_0000_03e8
`define PPCI_RES_MIN 40'h00_0000_0064
`define PPCI_RES_MAX 40'h00_0001_86a0

`endif

// >>> verilog/ppci_top.v
// pulse position command input with wishbone register slave
`timescale 1ns/10ps
`include "ppci_map.vh"

// Operation
// [RULE1] single-pulse mode: pulse line steps, direction line picks sense
// [RULE2] dual-pulse mode: cw line steps forward, ccw line steps reverse
// [RULE3] phase mode: second channel lagging first is forward, leading is reverse
// [RULE4] stored direction setting maps forward pulses to cw or ccw rotation
// [RULE5] setting 1: cw pulse increments position, turns cw; ccw decrements, ccw
// [RULE6] setting 0: cw pulse increments position, turns ccw; ccw decrements, cw
// [RULE7] resolution is 1000 times gear b divided by gear a
// [RULE8] resolution accepted only from 100 to 100000 pulses per revolution
// [RULE9] defaults give 1000 pulses per revolution, both gears one
// [RULE10] warning raised while resolution is out of range
// [RULE11] power-up with warning present escalates to gear alarm
// [RULE12] changed settings take effect only at next power-up
// [RULE13] absolute switch on enables absolute tracking, off disables, off default
// [RULE14] with backup power, position survives main supply loss
// [RULE15] inputs synchronised and edge detected, one step per pulse; phase mode steps on every edge of either channel, four per pulse cycle

module ppci_top (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // pulse inputs and switches
  input wire step_pulse_in_i,
  input wire dir_i,
  input wire pulse_mode_switch_i,
  input wire absolute_enable_switch_i,
  input wire backup_power_i,
  input wire power_up_i,
  // motor command and status
  output reg motor_step_o,
  output reg motor_cw_o,
  output reg abs_enable_o,
  output reg gear_warn_o,
  output reg gear_alarm_o,
  output reg irq_o
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  reg [5:0] meta_q;
  reg [5:0] sync_q;
  wire [5:0] raw_in;

  assign raw_in = {power_up_i, backup_power_i, absolute_enable_switch_i,
                   pulse_mode_switch_i, dir_i, step_pulse_in_i};

  // synchronisers run through reset, so the boot apply
  // already sees settled switch levels
  always @(posedge clk_i) begin
    meta_q <= raw_in;
    sync_q <= meta_q;
  end

  wire pwr_up_lvl;
  wire backup_ok;
  wire abs_sw;
  wire mode_sw;

  assign pwr_up_lvl = sync_q[5];
  assign backup_ok = sync_q[4];
  assign abs_sw = sync_q[3];
  assign mode_sw = sync_q[2];

  // ---------------------------------------------------------------
  // pending settings written by software
  // ---------------------------------------------------------------
  reg [`PPCI_CTRL_W-1:0] ctrl_q;
  reg [15:0] gear_a_q;
  reg [15:0] gear_b_q;
  reg [`PPCI_IRQ_W-1:0] irq_stat_q;
  reg [`PPCI_IRQ_W-1:0] irq_mask_q;

  // ---------------------------------------------------------------
  // active settings, loaded at power-up
  // ---------------------------------------------------------------
  reg [1:0] act_mode_q;
  reg act_pos_logic_q;
  reg act_rot_dir_q;
  reg boot_q;
  reg apply_q;
  reg pwr_up_prev_q;
  reg warn_prev_q;
  reg alarm_prev_q;
  reg [31:0] pos_q;

  wire apply;
  assign apply = boot_q | (pwr_up_lvl & ~pwr_up_prev_q);

  // gear range check without division
  wire [39:0] num;
  wire [39:0] lim_lo;
  wire [39:0] lim_hi;
  wire gear_ok;

  assign num = `PPCI_RES_BASE * {24'h00_0000, gear_b_q}; // RULE7
  assign lim_lo = `PPCI_RES_MIN * {24'h00_0000, gear_a_q};
  assign lim_hi = `PPCI_RES_MAX * {24'h00_0000, gear_a_q};
  assign gear_ok = (gear_a_q != 16'h0000) && (num >= lim_lo) && (num <= lim_hi); // RULE8

  wire warn;
  assign warn = ~gear_ok; // RULE10

  always @(posedge clk_i) begin
    if (rst_i) begin
      act_mode_q <= `PPCI_MODE_ONE;
      act_pos_logic_q <= 1'b0;
      act_rot_dir_q <= 1'b1;
      abs_enable_o <= 1'b0; // RULE13
      gear_alarm_o <= 1'b0;
      gear_warn_o <= 1'b0;
      boot_q <= 1'b1;
      apply_q <= 1'b0;
      pwr_up_prev_q <= 1'b0;
    end else begin
      boot_q <= 1'b0;
      apply_q <= apply;
      pwr_up_prev_q <= pwr_up_lvl;
      gear_warn_o <= warn;
      if (apply) begin
        if (ctrl_q[`PPCI_CTRL_MODE_SRC]) begin
          act_mode_q <= ctrl_q[`PPCI_CTRL_MODE_HI:`PPCI_CTRL_MODE_LO];
          act_pos_logic_q <= ctrl_q[`PPCI_CTRL_POS_LOGIC];
        end else begin
          act_mode_q <= mode_sw ? `PPCI_MODE_TWO : `PPCI_MODE_ONE;
          act_pos_logic_q <= 1'b0;
        end
        act_rot_dir_q <= ctrl_q[`PPCI_CTRL_ROT_DIR]; // RULE4 RULE12
        abs_enable_o <= abs_sw; // RULE13
        gear_alarm_o <= warn; // RULE11
      end
    end
  end

  // ---------------------------------------------------------------
  // pulse decode
  // ---------------------------------------------------------------
  reg ch_a_prev_q;
  reg ch_b_prev_q;
  wire ch_a;
  wire ch_b;

  // negative logic: active level is low on the line
  assign ch_a = act_pos_logic_q ? sync_q[0] : ~sync_q[0];
  assign ch_b = act_pos_logic_q ? sync_q[1] : ~sync_q[1];

  wire rise_a;
  wire rise_b;
  assign rise_a = ch_a & ~ch_a_prev_q; // RULE15
  assign rise_b = ch_b & ~ch_b_prev_q; // RULE15

  reg step;
  reg fwd;

  always @* begin
    step = 1'b0;
    fwd = 1'b1;
    case (act_mode_q)
      `PPCI_MODE_ONE: begin
        step = rise_a; // RULE1
        fwd = ~ch_b;
      end
      `PPCI_MODE_TWO: begin
        step = rise_a ^ rise_b; // RULE2
        fwd = rise_a;
      end
      `PPCI_MODE_PHASE: begin
        step = (ch_a ^ ch_a_prev_q) | (ch_b ^ ch_b_prev_q); // RULE3
        fwd = ch_a ^ ch_b_prev_q; // RULE3
      end
      default: begin
        step = 1'b0;
        fwd = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // command position and motor outputs
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ch_a_prev_q <= 1'b0;
      ch_b_prev_q <= 1'b0;
      pos_q <= 32'h0000_0000;
      motor_step_o <= 1'b0;
      motor_cw_o <= 1'b1;
    end else begin
      ch_a_prev_q <= ch_a;
      ch_b_prev_q <= ch_b;
      // a logic change at apply flips the channels once:
      // steps held off for the cycle after apply too
      motor_step_o <= step & ~gear_alarm_o & ~apply & ~apply_q; // RULE15
      if (apply) begin
        // position survives power-up only in absolute mode on backup
        if (!(abs_sw && backup_ok)) begin
          pos_q <= 32'h0000_0000; // RULE14
        end
      end else if (step && !gear_alarm_o && !apply_q) begin
        pos_q <= fwd ? pos_q + 32'h0000_0001 : pos_q - 32'h0000_0001; // RULE5 RULE6
        motor_cw_o <= fwd ~^ act_rot_dir_q; // RULE5 RULE6
      end
    end
  end

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  wire req;
  wire wr;
  wire [31:0] wmask;
  wire [31:0] ctrl_new;
  wire [31:0] ga_new;
  wire [31:0] gb_new;

  assign req = cyc_i & stb_i & ~ack_o;
  assign wr = req & we_i;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign ctrl_new = ({27'h000_0000, ctrl_q} & ~wmask) | (dat_i & wmask);
  assign ga_new = ({16'h0000, gear_a_q} & ~wmask) | (dat_i & wmask);
  assign gb_new = ({16'h0000, gear_b_q} & ~wmask) | (dat_i & wmask);

  wire [`PPCI_IRQ_W-1:0] irq_clr;
  wire [`PPCI_IRQ_W-1:0] irq_set;
  wire [`PPCI_IRQ_W-1:0] irq_mask_new;

  assign irq_clr = (wr && adr_i == `PPCI_OFS_IRQ_STAT && sel_i[0]) ? dat_i[`PPCI_IRQ_W-1:0] : 2'h0;
  assign irq_set = {gear_alarm_o & ~alarm_prev_q, warn & ~warn_prev_q};
  assign irq_mask_new = sel_i[0] ? dat_i[`PPCI_IRQ_W-1:0] : irq_mask_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `PPCI_CTRL_RST;
      gear_a_q <= `PPCI_GEAR_RST; // RULE9
      gear_b_q <= `PPCI_GEAR_RST; // RULE9
      irq_mask_q <= 2'h0;
    end else if (wr) begin
      case (adr_i)
        `PPCI_OFS_CTRL: ctrl_q <= ctrl_new[`PPCI_CTRL_W-1:0]; // RULE12
        `PPCI_OFS_GEAR_A: gear_a_q <= ga_new[15:0];
        `PPCI_OFS_GEAR_B: gear_b_q <= gb_new[15:0];
        `PPCI_OFS_IRQ_MASK: irq_mask_q <= irq_mask_new;
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // sticky events, set wins over clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= 2'h0;
      warn_prev_q <= 1'b0;
      alarm_prev_q <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      warn_prev_q <= warn;
      alarm_prev_q <= gear_alarm_o;
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      irq_o <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
    end
  end

  reg [31:0] rdata;

  always @* begin
    case (adr_i)
      `PPCI_OFS_CTRL: rdata = {27'h000_0000, ctrl_q};
      `PPCI_OFS_GEAR_A: rdata = {16'h0000, gear_a_q};
      `PPCI_OFS_GEAR_B: rdata = {16'h0000, gear_b_q};
      `PPCI_OFS_STATUS: rdata = {24'h00_0000, abs_enable_o, gear_alarm_o, gear_warn_o,
                                 act_rot_dir_q, act_pos_logic_q, 1'b0, act_mode_q};
      `PPCI_OFS_POS: rdata = pos_q;
      `PPCI_OFS_IRQ_STAT: rdata = {30'h0000_0000, irq_stat_q};
      `PPCI_OFS_IRQ_MASK: rdata = {30'h0000_0000, irq_mask_q};
      default: rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      dat_o <= req ? rdata : 32'h0000_0000;
    end
  end

endmodule // ppci_top

// >>> verification/ppci_assertions.sv
// port assertions for the pulse position command input
`timescale 1ns/10ps
module ppci_assertions (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // bus
  input wire cyc_i,
  input wire stb_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  // pins
  input wire step_pulse_in_i,
  input wire dir_i,
  input wire power_up_i,
  input wire motor_step_o,
  input wire motor_cw_o,
  input wire abs_enable_o,
  input wire gear_warn_o,
  input wire gear_alarm_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ---------------------------------------------------------------
  // bus, step stream, absolute enable and gear alarm
  // ---------------------------------------------------------------
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_pin_moved;
    $past(step_pulse_in_i, 3) != $past(step_pulse_in_i, 7) || $past(dir_i, 3) != $past(dir_i, 7);
  endsequence
  a_ack_latency: assert property (s_req |=> ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_step_pulse: assert property (motor_step_o |=> !motor_step_o)
    else $error("step pulse longer than one cycle");
  a_step_cause: assert property (motor_step_o |-> s_pin_moved)
    else $error("step without a pin edge");
  a_cw_with_step: assert property ($changed(motor_cw_o) |-> motor_step_o)
    else $error("rotation sense changed without step");
  a_abs_on_power: assert property ($changed(abs_enable_o) |-> power_up_i || $past(rst_i, 2))
    else $error("absolute enable changed outside power-up");
  a_alarm_set: assert property ($rose(gear_alarm_o) |-> gear_warn_o && power_up_i)
    else $error("gear alarm without warning at power-up");
  a_alarm_clear: assert property ($fell(gear_alarm_o) |-> !gear_warn_o && power_up_i)
    else $error("gear alarm cleared wrongly");
  a_alarm_blocks: assert property (gear_alarm_o |-> !motor_step_o)
    else $error("step while gear alarm");
endmodule // ppci_assertions
bind ppci_top ppci_assertions u_ppci_assertions (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o,
  .step_pulse_in_i, .dir_i, .power_up_i, .motor_step_o, .motor_cw_o, .abs_enable_o, .gear_warn_o,
  .gear_alarm_o);

// >>> verification/ppci_pulse_gen.sv
// pulse train source in place of the controller
`timescale 1ns/10ps
module ppci_pulse_gen (
  // clock
  input wire clk_i,
  // pulse lines
  output reg a_o,
  output reg b_o
);
  initial begin
    a_o = 1'b0;
    b_o = 1'b0;
  end
  // each level pair held four cycles
  task lv(input logic a, input logic b);
    begin
      @(posedge clk_i);
      a_o <= a;
      b_o <= b;
      repeat (3) @(posedge clk_i);
    end
  endtask
endmodule // ppci_pulse_gen

// >>> verification/tb.sv
// self-checking bench for the pulse position command input
`timescale 1ns/10ps
`include "ppci_map.vh"
module tb;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, pulse_mode_switch_i = 1'b0;
  reg absolute_enable_switch_i = 1'b0, backup_power_i = 1'b0, power_up_i = 1'b0;
  reg [7:0] adr_i = 8'h00;
  reg [3:0] sel_i = 4'hf;
  reg [31:0] dat_i = 32'h0000_0000, rdat, p0;
  wire [31:0] dat_o;
  wire ack_o, step_pulse_in_i, dir_i, motor_step_o, motor_cw_o, abs_enable_o, gear_warn_o, gear_alarm_o, irq_o;
  integer error_cnt = 0, check_count = 0, nstep = 0, m, v;
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) if (motor_step_o === 1'b1) nstep <= nstep + 1;
  ppci_top u_ppci_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .step_pulse_in_i, .dir_i, .pulse_mode_switch_i, .absolute_enable_switch_i, .backup_power_i, .power_up_i,
    .motor_step_o, .motor_cw_o, .abs_enable_o, .gear_warn_o, .gear_alarm_o, .irq_o);
  ppci_pulse_gen u_ppci_pulse_gen (.clk_i, .a_o(step_pulse_in_i), .b_o(dir_i));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task summarize;
    begin
      if (error_cnt == 0 && check_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    begin
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      n = 0;
      do begin
        @(posedge clk_i);
        n = n + 1;
      end while (ack_o !== 1'b1 && n < 50);
      if (ack_o !== 1'b1) begin
        error_cnt = error_cnt + 1;
        summarize;
      end
      rdat = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
    end
  endtask
  task pwr;
    begin
      repeat (4) @(posedge clk_i);
      power_up_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      power_up_i <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
  endtask
  task mv(input logic [1:0] md, input logic rd, input logic rev);
    integer s0;
    begin
      wb(1'b1, `PPCI_OFS_CTRL, {27'h0, rd, 2'b11, md});
      pwr;
      wb(1'b0, `PPCI_OFS_STATUS, 32'h0000_0000);
      chk("status", rdat & 32'h0000_001b, {27'h0, rd, 2'b10, md});
      wb(1'b0, `PPCI_OFS_POS, 32'h0000_0000);
      p0 = rdat;
      s0 = nstep;
      if (md == `PPCI_MODE_ONE) begin
        u_ppci_pulse_gen.lv(1'b0, rev);
        u_ppci_pulse_gen.lv(1'b1, rev);
        u_ppci_pulse_gen.lv(1'b0, rev);
      end else begin
        u_ppci_pulse_gen.lv(!rev, rev);
        if (md == `PPCI_MODE_PHASE) begin
          u_ppci_pulse_gen.lv(1'b1, 1'b1);
          u_ppci_pulse_gen.lv(rev, !rev);
        end
      end
      u_ppci_pulse_gen.lv(1'b0, 1'b0);
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      chk("cw", motor_cw_o, (!rev) == rd);
      chk("steps", nstep - s0, md == 2 ? 4 : 1);
      wb(1'b0, `PPCI_OFS_POS, 32'h0000_0000);
      chk("pos", rdat - p0, (rev ? -1 : 1) * (md == 2 ? 4 : 1));
    end
  endtask
  task gr(input logic [15:0] a, input logic [15:0] b, input logic w);
    begin
      wb(1'b1, `PPCI_OFS_GEAR_A, {16'h0, a});
      wb(1'b1, `PPCI_OFS_GEAR_B, {16'h0, b});
      repeat (2) @(negedge clk_i);
      chk("warn", gear_warn_o, w);
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset;
    begin
      wb(1'b0, `PPCI_OFS_GEAR_A, 32'h0000_0000);
      chk("gear_a", rdat, 32'h0000_0001);
      wb(1'b0, `PPCI_OFS_GEAR_B, 32'h0000_0000);
      chk("gear_b", rdat, 32'h0000_0001);
      chk("abs", abs_enable_o, 1'b0);
      wb(1'b0, 8'h1c, 32'h0000_0000);
      chk("unmapped", rdat, 32'h0000_0000);
      wb(1'b1, `PPCI_OFS_CTRL, 32'h0000_0006);
      wb(1'b0, `PPCI_OFS_STATUS, 32'h0000_0000);
      chk("status", rdat, 32'h0000_0010);
      pulse_mode_switch_i <= 1'b1;
      wb(1'b1, `PPCI_OFS_CTRL, 32'h0000_0010);
      pwr;
      wb(1'b0, `PPCI_OFS_STATUS, 32'h0000_0000);
      chk("status_sw", rdat, 32'h0000_0011);
      pulse_mode_switch_i <= 1'b0;
    end
  endtask
  task t_modes;
    for (m = 0; m < 3; m = m + 1)
      for (v = 0; v < 4; v = v + 1)
        mv(m[1:0], v[1], v[0]);
  endtask
  task t_abs;
    begin
      wb(1'b0, `PPCI_OFS_POS, 32'h0000_0000);
      p0 = rdat;
      absolute_enable_switch_i <= 1'b1;
      backup_power_i <= 1'b1;
      pwr;
      chk("abs", abs_enable_o, 1'b1);
      wb(1'b0, `PPCI_OFS_POS, 32'h0000_0000);
      chk("pos_kept", rdat, p0);
      backup_power_i <= 1'b0;
      pwr;
      wb(1'b0, `PPCI_OFS_POS, 32'h0000_0000);
      chk("pos_lost", rdat, 32'h0000_0000);
      absolute_enable_switch_i <= 1'b0;
      pwr;
      chk("abs", abs_enable_o, 1'b0);
    end
  endtask
  task t_gear;
    begin
      gr(16'h0001, 16'h0001, 1'b0);
      gr(16'h000a, 16'h0001, 1'b0);
      gr(16'h0001, 16'h0064, 1'b0);
      gr(16'h0001, 16'h0065, 1'b1);
      gr(16'h0000, 16'h0001, 1'b1);
      gr(16'h0064, 16'h0024, 1'b0);
      wb(1'b1, `PPCI_OFS_IRQ_MASK, 32'h0000_0003);
      wb(1'b1, `PPCI_OFS_IRQ_STAT, 32'h0000_0003);
      gr(16'h000b, 16'h0001, 1'b1);
      pwr;
      chk("alarm", gear_alarm_o, 1'b1);
      chk("irq", irq_o, 1'b1);
      wb(1'b0, `PPCI_OFS_IRQ_STAT, 32'h0000_0000);
      chk("irq_stat", rdat, 32'h0000_0003);
      wb(1'b0, `PPCI_OFS_POS, 32'h0000_0000);
      p0 = rdat;
      v = nstep;
      u_ppci_pulse_gen.lv(1'b1, 1'b0);
      u_ppci_pulse_gen.lv(1'b1, 1'b1);
      u_ppci_pulse_gen.lv(1'b0, 1'b0);
      wb(1'b0, `PPCI_OFS_POS, 32'h0000_0000);
      chk("pos_blocked", rdat, p0);
      chk("steps_blocked", nstep - v, 0);
      wb(1'b1, `PPCI_OFS_IRQ_MASK, 32'h0000_0000);
      repeat (2) @(negedge clk_i);
      chk("irq_masked", irq_o, 1'b0);
      wb(1'b1, `PPCI_OFS_IRQ_STAT, 32'h0000_0003);
      wb(1'b0, `PPCI_OFS_IRQ_STAT, 32'h0000_0000);
      chk("irq_clr", rdat, 32'h0000_0000);
      gr(16'h0001, 16'h0001, 1'b0);
      pwr;
      chk("alarm", gear_alarm_o, 1'b0);
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_reset;
    t_modes;
    t_abs;
    t_gear;
    summarize;
  end
endmodule // tb
